// ---- hdl/ubf_pkg.sv ----
// Constants, register map and carrier types for the serial clock/frame block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
// Notes on behaviour
// - Baud down-counter reloads divisor at zero and on low divisor byte write.
// - One baud tick per counter zero: rate is clock over divisor plus one.
// - Transmitter divides tick by 16 normal, 8 double speed, 2 sync master.
// - Receiver recovery steps 16 or 8 states per bit by mode; sync mode samples on the clock edge instead.
// - Divisor is 12 bits built from high and low register bytes.
// - Bit rate is clock over 16, 8 or 2 times divisor plus one.
// - Double speed acts only in asynchronous mode; sync mode ignores the bit.
// - Double speed makes receiver use 8 samples per bit, not 16.
// - Slave transfer clock is synchronised and edge detected; must be below clock/4.
// - Sync mode: transfer clock pin is input as slave, output as master.
// - Sync mode samples input on the edge opposite the output change edge.
// - Polarity clear: change on rise, sample on fall; set: the reverse.
// - All 30 formats: 5 to 9 data bits, no/even/odd parity, 1 or 2 stops.
// - Frame order: start, data LSB first, optional parity, stop bits.
// - Start low, stops and idle high; frames may follow back to back.
// - One shared format; changing it aborts transmit and receive in progress.
// - Receiver checks only first stop bit; frame error when it reads zero.
// - Parity is XOR of data bits for even, its inverse for odd.
// - Sync mode: pin direction output selects master, input selects slave.
// - Parity bit inserted only when upper parity mode bit is set.
// - Character size 7 selects nine-bit characters with separate ninth bit.
package ubf_pkg;
    localparam int DIV_W = 12;
    localparam int ADDR_W = 5;
    localparam int FRAME_W = 13;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_C = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_DIV_LOW = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_DIV_HIGH = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_CLK_DIR = 5'h18;
    localparam int CA_RXC = 7;
    localparam int CA_TXC = 6;
    localparam int CA_EMPTY = 5;
    localparam int CA_FE = 4;
    localparam int CA_PE = 2;
    localparam int CA_DBL = 1;
    localparam int CB_RXEN = 4;
    localparam int CB_TXEN = 3;
    localparam int CB_CS2 = 2;
    localparam int CB_RX9 = 1;
    localparam int CB_TX9 = 0;
    localparam int CC_SYNC = 6;
    localparam int CC_PM_HI = 5;
    localparam int CC_PM_LO = 4;
    localparam int CC_STOP = 3;
    localparam int CC_CS1 = 2;
    localparam int CC_CS0 = 1;
    localparam int CC_POL = 0;
    localparam logic [2:0] CHAR_SIZE_RST = 3'h3;
    localparam logic [2:0] CHAR_SIZE_9 = 3'h7;
    localparam logic [DIV_W-1:0] DIV_RST = 12'h000;
    localparam logic [3:0] TX_LAST_NORM = 4'hF;
    localparam logic [3:0] TX_LAST_DBL = 4'h7;
    localparam logic [3:0] RX_MID_NORM = 4'h8;
    localparam logic [3:0] RX_MID_DBL = 4'h4;

    typedef struct packed {
        logic [2:0] char_size;
        logic [1:0] parity_mode;
        logic stop_bits_select;
    } ubf_fmt_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } ubf_edge_t;
endpackage

// ---- hdl/ubf_usart_clkfmt.sv ----
// Baud generator, transfer clock handling and frame engine of a serial transceiver.
// Assumes a single 100 MHz clock, synchronous active-low reset and an Avalon-MM master.
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module ubf_usart_clkfmt (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [ubf_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic xfer_clock_pin_in,
    output logic xfer_clock_pin_out,
    output logic xfer_clock_pin_oe
);
    import ubf_pkg::*;

    // Register state
    logic [DIV_W-1:0] baud_divisor;
    logic double_speed, sync_mode_select, clock_polarity, xfer_clock_dir;
    logic tx_enable, rx_enable, tx_bit9;
    ubf_fmt_t fmt, fmt_q;
    logic tx_complete_flag, rx_complete_flag, frame_error, parity_error;
    logic [8:0] rx_data;
    logic rd_ack;

    // Bus decode
    wire wr_a = write && address == ADDR_CTRL_A;
    wire wr_b = write && address == ADDR_CTRL_B;
    wire wr_c = write && address == ADDR_CTRL_C;
    wire wr_lo = write && address == ADDR_DIV_LOW;
    wire wr_hi = write && address == ADDR_DIV_HIGH;
    wire wr_data = write && address == ADDR_DATA;
    wire wr_dir = write && address == ADDR_CLK_DIR;
    wire rd_take = read && rd_ack;
    wire rd_data = rd_take && address == ADDR_DATA;
    assign waitrequest = read && !rd_ack;

    // Mode decode
    wire dbl_eff = double_speed && !sync_mode_select;
    wire master = sync_mode_select && xfer_clock_dir;
    wire slave = sync_mode_select && !xfer_clock_dir;
    wire fmt_chg = fmt != fmt_q;
    wire [3:0] nbits = (fmt.char_size == CHAR_SIZE_9) ? 4'd9 :
        (fmt.char_size[2] ? 4'd8 : 4'(fmt.char_size[1:0]) + 4'd5);
    wire [8:0] data_mask = 9'h1FF >> (4'd9 - nbits);
    wire par_en = fmt.parity_mode[1];

    // Baud generator
    logic [DIV_W-1:0] baud_cnt;
    wire tick = baud_cnt == '0;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            baud_cnt <= DIV_RST;
        end else if (tick || wr_lo) begin
            baud_cnt <= wr_lo ? {baud_divisor[DIV_W-1:8], writedata[7:0]} : baud_divisor;
        end else begin
            baud_cnt <= baud_cnt - 12'h001;
        end
    end

    // Transmitter prescaler for asynchronous modes
    logic [3:0] tx_pre;
    wire [3:0] tx_last = dbl_eff ? TX_LAST_DBL : TX_LAST_NORM;
    wire tx_div_tick = tick && tx_pre == tx_last;
    always_ff @(posedge clock) begin
        if (!nrst || sync_mode_select) begin
            tx_pre <= 4'h0;
        end else if (tick) begin
            tx_pre <= (tx_pre == tx_last) ? 4'h0 : tx_pre + 4'h1;
        end
    end

    // Transfer clock: master output toggles per tick, slave input synchronised
    logic xck_out, xck_s1, xck_s2, xck_s3;
    ubf_edge_t m_edge, s_edge, xck_edge;
    assign m_edge = '{rise: tick && !xck_out, fall: tick && xck_out};
    assign s_edge = '{rise: xck_s2 && !xck_s3, fall: !xck_s2 && xck_s3};
    assign xck_edge = master ? m_edge : (slave ? s_edge : '0);
    wire edge_change = clock_polarity ? xck_edge.fall : xck_edge.rise;
    wire edge_sample = clock_polarity ? xck_edge.rise : xck_edge.fall;
    assign xfer_clock_pin_out = xck_out;
    assign xfer_clock_pin_oe = master;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            xck_out <= 1'b0;
            xck_s1 <= 1'b0;
            xck_s2 <= 1'b0;
            xck_s3 <= 1'b0;
        end else begin
            xck_out <= master ? (xck_out ^ tick) : 1'b0;
            xck_s1 <= xfer_clock_pin_in;
            xck_s2 <= xck_s1;
            xck_s3 <= xck_s2;
        end
    end

    // Transmit frame builder
    function automatic logic [FRAME_W-1:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                                       input logic [8:0] m, input logic [1:0] pm);
        logic [FRAME_W-1:0] fr;
        fr = '1;
        fr[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                fr[i + 1] = d[i];
            end
        end
        if (pm[1]) begin
            fr[int'(n) + 1] = ^(d & m) ^ pm[0];
        end
        return fr;
    endfunction

    // Transmitter
    logic [8:0] tx_buf;
    logic tx_pend, tx_busy;
    logic [FRAME_W-1:0] tx_sh;
    logic [3:0] tx_cnt;
    wire tx_bit = sync_mode_select ? edge_change : tx_div_tick;
    wire tx_end = tx_bit && tx_busy && tx_cnt == 4'h1;
    wire tx_load = tx_bit && tx_enable && tx_pend && (!tx_busy || tx_end);
    wire [3:0] tx_len = 4'h2 + nbits + {3'h0, par_en} + {3'h0, fmt.stop_bits_select};
    wire tx_done = tx_end && !tx_load;
    always_ff @(posedge clock) begin
        if (!nrst || fmt_chg) begin
            tx_busy <= 1'b0;
            tx_sh <= '1;
            tx_cnt <= 4'h0;
            serial_out <= 1'b1;
        end else if (tx_load) begin
            tx_busy <= 1'b1;
            tx_sh <= build_frame(tx_buf, nbits, data_mask, fmt.parity_mode);
            tx_cnt <= tx_len;
            serial_out <= 1'b0;
        end else if (tx_bit && tx_busy) begin
            tx_busy <= !tx_end;
            tx_sh <= tx_sh >> 1;
            tx_cnt <= tx_cnt - 4'h1;
            serial_out <= tx_end ? 1'b1 : tx_sh[1];
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst || fmt_chg) begin
            tx_pend <= 1'b0;
            tx_buf <= 9'h000;
        end else if (wr_data) begin
            tx_pend <= 1'b1;
            tx_buf <= {tx_bit9, writedata[7:0]};
        end else if (tx_load) begin
            tx_pend <= 1'b0;
        end
    end

    // Receiver recovery and frame checking
    logic rx_active;
    logic [3:0] rx_phase, rx_idx;
    logic [8:0] rx_sh;
    logic rx_par;
    wire [3:0] rx_last = dbl_eff ? TX_LAST_DBL : TX_LAST_NORM;
    wire [3:0] rx_mid = dbl_eff ? RX_MID_DBL : RX_MID_NORM;
    wire rx_start_async = !sync_mode_select && tick && !rx_active && rx_enable && !serial_in;
    wire rx_start_sync = sync_mode_select && edge_sample && !rx_active && rx_enable && !serial_in;
    wire rx_samp = rx_active && (sync_mode_select ? edge_sample : (tick && rx_phase == rx_mid));
    wire rx_is_data = rx_idx != 4'h0 && rx_idx <= nbits;
    wire rx_is_par = par_en && rx_idx == nbits + 4'h1;
    wire rx_is_stop = rx_idx != 4'h0 && !rx_is_data && !rx_is_par;
    wire rx_false = rx_samp && rx_idx == 4'h0 && serial_in;
    wire rx_done = rx_samp && rx_is_stop;
    wire rx_par_exp = ^(rx_sh & data_mask) ^ fmt.parity_mode[0];
    always_ff @(posedge clock) begin
        if (!nrst || fmt_chg) begin
            rx_active <= 1'b0;
            rx_phase <= 4'h0;
            rx_idx <= 4'h0;
        end else if (rx_start_async || rx_start_sync) begin
            rx_active <= 1'b1;
            rx_phase <= 4'h1;
            rx_idx <= rx_start_sync ? 4'h1 : 4'h0;
        end else if (rx_active) begin
            if (tick && !sync_mode_select) begin
                rx_phase <= (rx_phase == rx_last) ? 4'h0 : rx_phase + 4'h1;
            end
            if (rx_samp) begin
                rx_idx <= rx_idx + 4'h1;
            end
            if (rx_false || rx_done) begin
                rx_active <= 1'b0;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rx_sh <= 9'h000;
            rx_par <= 1'b0;
        end else if (rx_start_async || rx_start_sync) begin
            rx_sh <= 9'h000;
        end else if (rx_samp && rx_is_data) begin
            rx_sh[rx_idx - 4'h1] <= serial_in;
        end else if (rx_samp && rx_is_par) begin
            rx_par <= serial_in;
        end
    end

    // Flags and received character
    always_ff @(posedge clock) begin
        if (!nrst) begin
            tx_complete_flag <= 1'b0;
            rx_complete_flag <= 1'b0;
            frame_error <= 1'b0;
            parity_error <= 1'b0;
            rx_data <= 9'h000;
        end else begin
            tx_complete_flag <= tx_done || (tx_complete_flag && !(wr_a && writedata[CA_TXC]));
            rx_complete_flag <= rx_done || (rx_complete_flag && !rd_data);
            if (rx_done) begin
                frame_error <= !serial_in;
                parity_error <= par_en && (rx_par != rx_par_exp);
                rx_data <= rx_sh & data_mask;
            end
        end
    end

    // Control registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            baud_divisor <= DIV_RST;
            double_speed <= 1'b0;
            tx_enable <= 1'b0;
            rx_enable <= 1'b0;
            tx_bit9 <= 1'b0;
            sync_mode_select <= 1'b0;
            clock_polarity <= 1'b0;
            xfer_clock_dir <= 1'b0;
            fmt <= '{char_size: CHAR_SIZE_RST, parity_mode: 2'b00, stop_bits_select: 1'b0};
            fmt_q <= '{char_size: CHAR_SIZE_RST, parity_mode: 2'b00, stop_bits_select: 1'b0};
        end else begin
            fmt_q <= fmt;
            if (wr_lo) begin
                baud_divisor[7:0] <= writedata[7:0];
            end
            if (wr_hi) begin
                baud_divisor[DIV_W-1:8] <= writedata[3:0];
            end
            if (wr_a) begin
                double_speed <= writedata[CA_DBL];
            end
            if (wr_b) begin
                rx_enable <= writedata[CB_RXEN];
                tx_enable <= writedata[CB_TXEN];
                fmt.char_size[2] <= writedata[CB_CS2];
                tx_bit9 <= writedata[CB_TX9];
            end
            if (wr_c) begin
                sync_mode_select <= writedata[CC_SYNC];
                fmt.parity_mode <= writedata[CC_PM_HI:CC_PM_LO];
                fmt.stop_bits_select <= writedata[CC_STOP];
                fmt.char_size[1:0] <= writedata[CC_CS1:CC_CS0];
                clock_polarity <= writedata[CC_POL];
            end
            if (wr_dir) begin
                xfer_clock_dir <= writedata[0];
            end
        end
    end

    // Read path with one wait state
    wire [7:0] reg_a = {rx_complete_flag, tx_complete_flag, !tx_pend, frame_error, 1'b0, parity_error,
                        double_speed, 1'b0};
    wire [7:0] reg_b = {3'h0, rx_enable, tx_enable, fmt.char_size[2], rx_data[8], tx_bit9};
    wire [7:0] reg_c = {1'b0, sync_mode_select, fmt.parity_mode, fmt.stop_bits_select,
                        fmt.char_size[1:0], clock_polarity};
    wire [7:0] rd_mux = (address == ADDR_CTRL_A) ? reg_a :
                        (address == ADDR_CTRL_B) ? reg_b :
                        (address == ADDR_CTRL_C) ? reg_c :
                        (address == ADDR_DIV_LOW) ? baud_divisor[7:0] :
                        (address == ADDR_DIV_HIGH) ? {4'h0, baud_divisor[DIV_W-1:8]} :
                        (address == ADDR_DATA) ? rx_data[7:0] :
                        (address == ADDR_CLK_DIR) ? {7'h00, xfer_clock_dir} : 8'h00;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_ack <= 1'b0;
            readdata <= 32'h00000000;
        end else begin
            rd_ack <= read && !rd_ack;
            if (read && !rd_ack) begin
                readdata <= {24'h000000, rd_mux};
            end
        end
    end

    // Helper: cycles between baud ticks
    logic [DIV_W-1:0] gap_cnt;
    logic gap_ok;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            gap_cnt <= '0;
            gap_ok <= 1'b0;
        end else begin
            gap_cnt <= tick ? '0 : gap_cnt + 12'h001;
            gap_ok <= (wr_lo || wr_hi) ? 1'b0 : (tick ? 1'b1 : gap_ok);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_baud_reload: assert property ((tick && !wr_lo && !wr_hi) |=> baud_cnt == $past(baud_divisor))
        else $error("baud counter did not reload at zero");
    a_low_write_load: assert property (wr_lo |=> baud_cnt == baud_divisor)
        else $error("baud counter did not reload on low byte write");
    a_tick_spacing: assert property ((tick && gap_ok && !wr_lo && !wr_hi) |-> gap_cnt == baud_divisor)
        else $error("baud tick spacing differs from divisor plus one");
    a_tx_prescale: assert property ((tx_bit && !sync_mode_select) |-> (tick && tx_pre == (dbl_eff ? 4'h7 : 4'hF)))
        else $error("asynchronous transmit bit not on prescaler wrap");
    a_master_toggle: assert property ((master && $changed(xck_out)) |-> $past(tick))
        else $error("master transfer clock changed without baud tick");
    a_slave_sync_delay: assert property ((slave && xck_edge.rise) |-> ($past(xfer_clock_pin_in, 2) && !$past(xfer_clock_pin_in, 3)))
        else $error("slave clock edge not two cycles after pin edge");
    a_tx_start_low: assert property ($rose(tx_busy) |-> !serial_out)
        else $error("frame did not begin with a low start bit");
    a_tx_idle_high: assert property ((tx_done && !fmt_chg) |=> (serial_out && !tx_busy))
        else $error("line not high after last stop bit");
    a_fmt_abort: assert property (fmt_chg |=> (!tx_busy && !rx_active && !tx_pend))
        else $error("format change did not abort transfers");
    a_frame_error: assert property (rx_done |=> frame_error == !$past(serial_in))
        else $error("frame error does not match first stop bit");
    a_rx_mid_sample: assert property ((rx_samp && !sync_mode_select) |-> (tick && rx_phase == (dbl_eff ? 4'h4 : 4'h8)))
        else $error("asynchronous sample not at mid bit");
endmodule // ubf_usart_clkfmt

// ---- tb/tb.sv ----
// Self-checking bench for the serial clock and frame block.
// Assumes ubf_pkg, the design and the peer model are compiled first.
`timescale 1ns/1ns
module tb;
    import ubf_pkg::*;
    logic clock, nrst, read, write, waitrequest, serial_in, serial_out, xck_in, xck_out, xck_oe;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata, readdata, rd;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    ubf_usart_clkfmt u_dut (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .serial_in(serial_in),
        .serial_out(serial_out), .xfer_clock_pin_in(xck_in), .xfer_clock_pin_out(xck_out),
        .xfer_clock_pin_oe(xck_oe));
    ubf_peer u_peer (.clock(clock), .line_rx(serial_out), .line_tx(serial_in), .xck_drive(xck_in));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        write <= 1'b1;
        address <= a;
        writedata <= {24'h000000, d};
        do @(posedge clock); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    task automatic bus_rd(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        read <= 1'b1;
        address <= a;
        do @(posedge clock); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
    endtask
    task automatic wait_lvl(input logic v, inout int t);
        while (xck_out !== v && t < 200) begin
            @(posedge clock);
            t++;
        end
    endtask
    function automatic int nbits(input logic [2:0] cs);
        return (cs == CHAR_SIZE_9) ? 9 : (cs > 3'h3) ? 8 : 5 + int'(cs);
    endfunction
    function automatic logic [12:0] frame(input logic [8:0] d, input logic [2:0] cs, input logic [1:0] pm,
        input logic sb, output int n);
        logic p;
        frame = '1;
        frame[0] = 1'b0;
        p = pm[0];
        for (int i = 0; i < nbits(cs); i++) begin
            frame[1 + i] = d[i];
            p = p ^ d[i];
        end
        n = 1 + nbits(cs);
        if (pm[1]) begin
            frame[n] = p;
            n++;
        end
        n = n + (sb ? 2 : 1);
    endfunction
    task automatic t_reset();
        check({31'h0, serial_out}, 32'h1);
        check({31'h0, xck_oe}, 32'h0);
        bus_rd(ADDR_CTRL_C);
        check(rd, 32'h06);
        bus_rd(5'h1C);
        check(rd, 32'h0);
        bus_wr(ADDR_DIV_HIGH, 8'hFF);
        bus_rd(ADDR_DIV_HIGH);
        check(rd, 32'h0F);
        $display("reset and register test done");
    endtask
    task automatic t_format(input logic [2:0] cs, input logic [1:0] pm, input logic sb, input logic dbl,
        input logic [11:0] dv, input logic [8:0] d);
        logic [12:0] exp, got;
        logic [7:0] m;
        int n, bt;
        bit ok;
        exp = frame(d, cs, pm, sb, n);
        bt = (dbl ? 8 : 16) * (int'(dv) + 1);
        m = (nbits(cs) >= 8) ? 8'hFF : (8'hFF >> (8 - nbits(cs)));
        bus_wr(ADDR_DIV_HIGH, {4'h0, dv[11:8]});
        bus_wr(ADDR_DIV_LOW, dv[7:0]);
        bus_wr(ADDR_CTRL_A, {6'h10, dbl, 1'b0});
        bus_wr(ADDR_CTRL_C, {2'b00, pm, sb, cs[1:0], 1'b0});
        bus_wr(ADDR_CTRL_B, {5'h03, cs[2], 1'b0, d[8]});
        bus_wr(ADDR_DATA, d[7:0]);
        u_peer.recv_bits(got, n, bt, ok);
        check({31'h0, ok}, 32'h1);
        check({19'h0, got}, {19'h0, exp});
        u_peer.send_bits(exp, n, bt);
        bus_rd(ADDR_CTRL_A);
        check(rd & 32'h94, 32'h80);
        if (cs == CHAR_SIZE_9) begin
            bus_rd(ADDR_CTRL_B);
            check(rd & 32'h2, {30'h0, d[8], 1'b0});
        end
        bus_rd(ADDR_DATA);
        check(rd, {24'h0, d[7:0] & m});
        $display("format test done, size %0d parity %0d stops %0d", nbits(cs), pm, sb + 1);
    endtask
    task automatic t_stop_err();
        logic [12:0] f;
        int n;
        f = frame(9'h03C, 3'h3, 2'b00, 1'b1, n);
        bus_wr(ADDR_DIV_LOW, 8'h00);
        bus_wr(ADDR_CTRL_A, 8'h40);
        bus_wr(ADDR_CTRL_C, 8'h0E);
        f[9] = 1'b0;
        u_peer.send_bits(f, n, 16);
        bus_rd(ADDR_CTRL_A);
        check(rd & 32'h10, 32'h10);
        repeat (300) @(posedge clock);
        bus_rd(ADDR_DATA);
        f[9] = 1'b1;
        f[10] = 1'b0;
        u_peer.send_bits(f, n, 16);
        bus_rd(ADDR_CTRL_A);
        check(rd & 32'h10, 32'h0);
        bus_rd(ADDR_DATA);
        check(rd, 32'h3C);
        repeat (300) @(posedge clock);
        bus_rd(ADDR_DATA);
        $display("stop bit test done");
    endtask
    task automatic t_abort();
        int bad;
        bad = 0;
        bus_wr(ADDR_CTRL_C, 8'h06);
        bus_wr(ADDR_DATA, 8'h00);
        repeat (60) @(posedge clock);
        check({31'h0, serial_out}, 32'h0);
        bus_wr(ADDR_CTRL_C, 8'h08);
        repeat (2) @(posedge clock);
        repeat (400) begin
            @(posedge clock);
            bad = bad + (serial_out !== 1'b1);
        end
        check(32'(bad), 32'h0);
        $display("format change test done");
    endtask
    task automatic t_sync();
        int t;
        int n;
        logic [12:0] got, exp;
        bus_wr(ADDR_DIV_LOW, 8'h02);
        bus_wr(ADDR_CLK_DIR, 8'h01);
        for (int k = 0; k < 2; k++) begin
            bus_wr(ADDR_CTRL_A, {6'h10, k[0], 1'b0});
            bus_wr(ADDR_CTRL_C, 8'h46);
            bus_wr(ADDR_DATA, 8'hA5);
            check({31'h0, xck_oe}, 32'h1);
            t = 0;
            wait_lvl(1'b0, t);
            wait_lvl(1'b1, t);
            t = 0;
            wait_lvl(1'b0, t);
            wait_lvl(1'b1, t);
            check(32'(t), 32'h6);
        end
        bus_wr(ADDR_CLK_DIR, 8'h00);
        @(posedge clock);
        check({31'h0, xck_oe}, 32'h0);
        exp = frame(9'h0A5, 3'h3, 2'b00, 1'b1, n);
        bus_wr(ADDR_CTRL_C, 8'h4E);
        bus_wr(ADDR_DATA, 8'hA5);
        u_peer.slave_bits(got, 10);
        check({19'h0, got}, {19'h0, exp});
        $display("synchronous clock test done");
    endtask
    initial begin
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_format(3'h3, 2'b00, 1'b0, 1'b0, 12'h001, 9'h0A5);
        t_format(3'h2, 2'b10, 1'b1, 1'b1, 12'h000, 9'h05B);
        t_format(3'h0, 2'b11, 1'b0, 1'b0, 12'h000, 9'h013);
        t_format(3'h7, 2'b11, 1'b1, 1'b1, 12'h002, 9'h1C6);
        t_format(3'h1, 2'b10, 1'b0, 1'b0, 12'h000, 9'h02D);
        t_stop_err();
        t_abort();
        t_sync();
        final_report();
    end
endmodule // tb

// ---- tb/ubf_peer.sv ----
// Remote serial peer: sends and receives asynchronous frames bit by bit.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ns
module ubf_peer (
    input wire logic clock,
    input wire logic line_rx,
    output logic line_tx,
    output logic xck_drive
);
    initial begin
        line_tx = 1'b1;
        xck_drive = 1'b0;
    end
    task automatic send_bits(input logic [12:0] f, input int n, input int bt);
        for (int i = 0; i < n; i++) begin
            line_tx <= f[i];
            repeat (bt) @(posedge clock);
        end
        line_tx <= 1'b1;
    endtask
    task automatic slave_bits(output logic [12:0] f, input int n);
        f = '1;
        for (int i = 0; i < n; i++) begin
            xck_drive <= 1'b1;
            repeat (4) @(posedge clock);
            f[i] = line_rx;
            xck_drive <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask
    task automatic recv_bits(output logic [12:0] f, input int n, input int bt, output bit ok);
        int w;
        f = '1;
        w = 0;
        while (line_rx !== 1'b0 && w < 40000) begin
            @(posedge clock);
            w++;
        end
        repeat (bt / 2) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                repeat (bt) @(posedge clock);
            end
            f[i] = line_rx;
        end
        ok = (w < 40000);
    endtask
endmodule // ubf_peer
